// ==== vpi_pkg.sv ====
`default_nettype none
package vpi_pkg;

    // ==========================================================
    // Addressing
    localparam logic [6:0] MODULE_ADDR = 7'h44;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
    localparam int NUM_REGS = 16;
    localparam int INDEX_W = 4;
    localparam logic [3:0] INDEX_PAGE = 4'h0;
    localparam logic [3:0] IDX_RSVD_A = 4'hb;
    localparam logic [3:0] IDX_RSVD_B = 4'he;
    localparam logic [3:0] IDX_RSVD_C = 4'hf;
    localparam logic [3:0] IDX_CTRL1 = 4'hc;
    localparam int CTRL1_DEFER_BIT = 5;

    // ==========================================================
    // Framing and status layout
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam int STAT_SUPPLY_BIT = 7;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic SUPPLY_FLAG_RESET = 1'b1;
    localparam logic [7:0] READ_FILL = 8'hff;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int SCL_PERIOD_NS = 10000;
    localparam int SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

    // ==========================================================
    // State types
    typedef enum logic [2:0] {
        D_IDLE = 3'b000,
        D_ADDR = 3'b001,
        D_INDEX = 3'b011,
        D_DATA = 3'b010,
        D_READ = 3'b110,
        D_IGNORE = 3'b100
    } vpi_dev_state_e;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_START = 3'b001,
        H_BIT = 3'b011,
        H_NEXT = 3'b010,
        H_STOP = 3'b110
    } vpi_host_state_e;

    // Reserved indexes are accepted but change nothing
    function automatic logic vpi_is_live(input logic [3:0] idx);
        vpi_is_live = (idx != IDX_RSVD_A) && (idx != IDX_RSVD_B) && (idx != IDX_RSVD_C);
    endfunction : vpi_is_live

endpackage : vpi_pkg
`default_nettype wire

// ==== vpi_i2c_if.sv ====
`default_nettype none
interface vpi_i2c_if;
    logic scl;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic sda;

    // Open-drain wire with pull-up
    assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));

    modport host (output scl, output sda_host_o, output sda_host_oe, input sda);
    modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
endinterface : vpi_i2c_if
`default_nettype wire

// ==== vpi_i2c_device.sv ====
// Summary of operation
// - Transmitter changes SDA only while SCL low
// - SDA falling while SCL high starts
// - SDA rising while SCL high stops
// - Master brackets every transfer with start, stop
// - Bus busy from start until stop
// - Transfer carries address, index, data bytes
// - Receiver acknowledges each byte in ninth clock
// - Answer only address 88 write, 89 read
// - Write transfers have no length limit only with deferred update off
// - Master sends address and index before data
// - Single write: address, index, one data
// - Auto-increment only with deferred update off
// - Deferred update executes writes at blanking
// - Reads return white-level comparison results
// - Index steps per data byte, wraps 0f
// - Index above 0f not acknowledged, ignored
// - Deferred data buffered, blocks new until moved
// - Status byte: supply flag, blue, green, red, zero
`default_nettype none
module vpi_i2c_device (
    // Serial link
    vpi_i2c_if.device link,
    // System clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Video timing and measurement
    input wire logic vblank,
    input wire logic supply_drop,
    input wire logic [5:0] white_result,
    // Working parameters
    output logic [8*vpi_pkg::NUM_REGS-1:0] work_regs,
    output logic deferred_pending
);

    // ==========================================================
    // Start and stop capture on SDA edges
    logic start_tog;
    logic stop_tog;

    always_ff @(negedge link.sda or negedge resetn) begin
        if (!resetn) begin
            start_tog <= 1'b0;
        end else if (link.scl) begin
            start_tog <= ~start_tog;
        end
    end

    always_ff @(posedge link.sda or negedge resetn) begin
        if (!resetn) begin
            stop_tog <= 1'b0;
        end else if (link.scl) begin
            stop_tog <= ~stop_tog;
        end
    end

    // ==========================================================
    // Link side, clocked by SCL
    vpi_pkg::vpi_dev_state_e state;
    logic start_ack;
    logic [3:0] cnt;
    logic [6:0] shift;
    logic ack_go;
    logic data_done;
    logic [3:0] idx;
    logic [3:0] wr_idx;
    logic [7:0] wr_data;
    logic wr_tog;
    logic rd_tog;
    logic [1:0] hold_s;
    logic [1:0] defer_s;
    logic sda_oe;
    logic sda_o;
    logic [7:0] stat_snap;
    logic busy;

    // Start toggle is stable long before the next SCL rise
    wire start_seen = start_tog != start_ack;
    wire [7:0] byte_in = {shift, link.sda};
    wire byte_end = cnt == vpi_pkg::BIT_LAST;
    wire addr_hit = byte_in[7:1] == vpi_pkg::MODULE_ADDR;
    wire index_ok = (byte_in[7:4] == vpi_pkg::INDEX_PAGE) && !hold_s[1];
    wire data_ok = !hold_s[1] && !(defer_s[1] && data_done);
    wire in_ack = cnt == vpi_pkg::BIT_ACK;
    wire [2:0] tx_pos = 3'h7 - cnt[2:0];

    always_ff @(posedge link.scl or negedge resetn) begin
        if (!resetn) begin
            hold_s <= 2'b00;
            defer_s <= 2'b00;
        end else begin
            hold_s <= {hold_s[0], deferred_pending};
            defer_s <= {defer_s[0], work_regs[8*vpi_pkg::IDX_CTRL1 + vpi_pkg::CTRL1_DEFER_BIT]};
        end
    end

    always_ff @(posedge link.scl or negedge resetn) begin
        if (!resetn) begin
            state <= vpi_pkg::D_IDLE;
            start_ack <= 1'b0;
            cnt <= 4'h0;
            shift <= 7'h00;
            ack_go <= 1'b0;
            data_done <= 1'b0;
            idx <= 4'h0;
            wr_idx <= 4'h0;
            wr_data <= 8'h00;
            wr_tog <= 1'b0;
            rd_tog <= 1'b0;
        end else if (start_seen) begin
            start_ack <= start_tog;
            state <= vpi_pkg::D_ADDR;
            shift <= {6'h00, link.sda};
            cnt <= 4'h1;
            ack_go <= 1'b0;
            data_done <= 1'b0;
        end else if (in_ack) begin
            cnt <= 4'h0;
            ack_go <= 1'b0;
            if (state == vpi_pkg::D_READ && link.sda) begin
                state <= vpi_pkg::D_IGNORE;
            end
        end else begin
            shift <= byte_in[6:0];
            cnt <= cnt + 4'h1;
            if (byte_end) begin
                case (state)
                    vpi_pkg::D_ADDR: begin
                        if (addr_hit) begin
                            ack_go <= 1'b1;
                            state <= (byte_in[0] == vpi_pkg::DIR_READ) ? vpi_pkg::D_READ
                                                                       : vpi_pkg::D_INDEX;
                        end else begin
                            state <= vpi_pkg::D_IGNORE;
                        end
                    end
                    vpi_pkg::D_INDEX: begin
                        if (index_ok) begin
                            ack_go <= 1'b1;
                            idx <= byte_in[3:0];
                            state <= vpi_pkg::D_DATA;
                        end else begin
                            state <= vpi_pkg::D_IGNORE;
                        end
                    end
                    vpi_pkg::D_DATA: begin
                        // No byte limit; deferred mode takes one byte only
                        if (data_ok) begin
                            ack_go <= 1'b1;
                            wr_idx <= idx;
                            wr_data <= byte_in;
                            wr_tog <= ~wr_tog;
                            idx <= idx + 4'h1;
                            data_done <= 1'b1;
                        end else begin
                            state <= vpi_pkg::D_IGNORE;
                        end
                    end
                    vpi_pkg::D_READ: begin
                        rd_tog <= ~rd_tog;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Drive on the falling edge so SDA is steady while SCL is high
    always_ff @(negedge link.scl or negedge resetn) begin
        if (!resetn) begin
            sda_oe <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
            sda_oe <= (in_ack && ack_go)
                || (state == vpi_pkg::D_READ && !in_ack && !stat_snap[tx_pos]);
        end
    end

    assign link.sda_dev_oe = sda_oe;
    assign link.sda_dev_o = sda_o;

    // ==========================================================
    // System side synchronisers
    logic [2:0] wr_s;
    logic [2:0] start_s;
    logic [2:0] stop_s;
    logic [2:0] rd_s;
    logic [2:0] vb_s;
    logic [2:0] drop_s;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_s <= 3'h0;
            start_s <= 3'h0;
            stop_s <= 3'h0;
            rd_s <= 3'h0;
            vb_s <= 3'h0;
            drop_s <= 3'h0;
        end else begin
            wr_s <= {wr_s[1:0], wr_tog};
            start_s <= {start_s[1:0], start_tog};
            stop_s <= {stop_s[1:0], stop_tog};
            rd_s <= {rd_s[1:0], rd_tog};
            vb_s <= {vb_s[1:0], vblank};
            drop_s <= {drop_s[1:0], supply_drop};
        end
    end

    wire wr_ev = wr_s[2] ^ wr_s[1];
    wire start_ev = start_s[2] ^ start_s[1];
    wire stop_ev = stop_s[2] ^ stop_s[1];
    wire rd_ev = rd_s[2] ^ rd_s[1];
    wire vb_rise = vb_s[1] && !vb_s[2];
    wire drop_lvl = drop_s[1];
    wire drop_rise = drop_s[1] && !drop_s[2];
    wire defer_on = work_regs[8*vpi_pkg::IDX_CTRL1 + vpi_pkg::CTRL1_DEFER_BIT];

    // ==========================================================
    // Parameter store, buffer and status
    logic [3:0] pend_idx;
    logic [7:0] pend_data;
    logic supply_flag;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            work_regs <= {vpi_pkg::NUM_REGS{vpi_pkg::REG_RESET}};
            deferred_pending <= 1'b0;
            pend_idx <= 4'h0;
            pend_data <= 8'h00;
        end else if (drop_rise) begin
            // Supply loss clears every parameter
            work_regs <= {vpi_pkg::NUM_REGS{vpi_pkg::REG_RESET}};
            deferred_pending <= 1'b0;
        end else if (deferred_pending) begin
            if (vb_rise) begin
                if (vpi_pkg::vpi_is_live(pend_idx)) begin
                    work_regs[{pend_idx, 3'b000} +: 8] <= pend_data;
                end
                deferred_pending <= 1'b0;
            end
        end else if (wr_ev) begin
            if (defer_on) begin
                deferred_pending <= 1'b1;
                pend_idx <= wr_idx;
                pend_data <= wr_data;
            end else if (vpi_pkg::vpi_is_live(wr_idx)) begin
                work_regs[{wr_idx, 3'b000} +: 8] <= wr_data;
            end
        end
    end

    // Snapshot frozen while busy so the SCL side reads stable bits
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy <= 1'b0;
            supply_flag <= vpi_pkg::SUPPLY_FLAG_RESET;
            stat_snap <= 8'h00;
        end else begin
            if (stop_ev) begin
                busy <= 1'b0;
            end else if (start_ev) begin
                busy <= 1'b1;
            end
            if (drop_lvl) begin
                supply_flag <= 1'b1;
            end else if (rd_ev) begin
                supply_flag <= 1'b0;
            end
            if (!busy) begin
                stat_snap <= {supply_flag, white_result, 1'b0};
            end
        end
    end

endmodule : vpi_i2c_device
`default_nettype wire

// ==== vpi_i2c_host.sv ====
`default_nettype none
module vpi_i2c_host #(
    parameter int QUARTER = vpi_pkg::SCL_QUARTER_CYC
) (
    // Serial link
    vpi_i2c_if.host link,
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Request stream
    input wire logic req_valid,
    input wire logic req_read,
    input wire logic [7:0] req_data,
    input wire logic req_last,
    output logic req_ready,
    // Answer
    output logic resp_valid,
    output logic [7:0] resp_data,
    output logic resp_nack,
    output logic busy
);

    // ==========================================================
    // Quarter-bit timebase
    localparam logic [15:0] QMAX = 16'(QUARTER - 1);

    vpi_pkg::vpi_host_state_e state;
    logic [1:0] sda_s;
    logic [15:0] qc;
    logic [1:0] ph;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic rd;
    logic last;
    logic scl_r;
    logic oe_r;

    wire tick = qc == QMAX;
    wire waiting = (state == vpi_pkg::H_IDLE) || (state == vpi_pkg::H_NEXT);
    wire take = req_valid && !req_ready;
    wire in_ack = bitc == vpi_pkg::BIT_ACK;
    // Read: release data bits, acknowledge all but the last byte
    wire bit_oe = rd ? (in_ack && !last) : (!in_ack && !sh[7]);

    // SDA is driven from the far end, so it is synchronised first
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sda_s <= 2'h3;
            qc <= 16'h0000;
        end else begin
            sda_s <= {sda_s[0], link.sda};
            qc <= (tick || waiting) ? 16'h0000 : qc + 16'h0001;
        end
    end

    // ==========================================================
    // Framing; SDA moves a quarter away from any SCL edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= vpi_pkg::H_IDLE;
            ph <= 2'h0;
            bitc <= 4'h0;
            sh <= 8'h00;
            rd <= 1'b0;
            last <= 1'b0;
            scl_r <= 1'b1;
            oe_r <= 1'b0;
            req_ready <= 1'b0;
            resp_valid <= 1'b0;
            resp_data <= 8'h00;
            resp_nack <= 1'b0;
            busy <= 1'b0;
        end else begin
            req_ready <= 1'b0;
            resp_valid <= 1'b0;
            case (state)
                vpi_pkg::H_IDLE, vpi_pkg::H_NEXT: begin
                    if (take) begin
                        req_ready <= 1'b1;
                        busy <= 1'b1;
                        sh <= req_data;
                        rd <= req_read;
                        last <= req_last;
                        ph <= 2'h0;
                        bitc <= 4'h0;
                        state <= waiting && (state == vpi_pkg::H_IDLE) ? vpi_pkg::H_START
                                                                      : vpi_pkg::H_BIT;
                    end
                end
                vpi_pkg::H_START: begin
                    if (tick) begin
                        if (ph == 2'h0) begin
                            oe_r <= 1'b1;
                            ph <= 2'h1;
                        end else begin
                            scl_r <= 1'b0;
                            ph <= 2'h0;
                            state <= vpi_pkg::H_BIT;
                        end
                    end
                end
                vpi_pkg::H_BIT: begin
                    if (tick) begin
                        ph <= ph + 2'h1;
                        case (ph)
                            2'h0: begin
                                oe_r <= bit_oe;
                            end
                            2'h1: begin
                                scl_r <= 1'b1;
                            end
                            2'h2: begin
                                if (in_ack) begin
                                    resp_nack <= sda_s[1];
                                end else begin
                                    sh <= {sh[6:0], sda_s[1]};
                                end
                            end
                            default: begin
                                scl_r <= 1'b0;
                                if (in_ack) begin
                                    resp_valid <= 1'b1;
                                    resp_data <= sh;
                                    state <= last ? vpi_pkg::H_STOP : vpi_pkg::H_NEXT;
                                end else begin
                                    bitc <= bitc + 4'h1;
                                end
                            end
                        endcase
                    end
                end
                vpi_pkg::H_STOP: begin
                    if (tick) begin
                        ph <= ph + 2'h1;
                        case (ph)
                            2'h0: begin
                                oe_r <= 1'b1;
                            end
                            2'h1: begin
                                scl_r <= 1'b1;
                            end
                            2'h2: begin
                                oe_r <= 1'b0;
                            end
                            default: begin
                                busy <= 1'b0;
                                state <= vpi_pkg::H_IDLE;
                            end
                        endcase
                    end
                end
                default: begin
                    state <= vpi_pkg::H_IDLE;
                end
            endcase
        end
    end

    assign link.scl = scl_r;
    assign link.sda_host_oe = oe_r;
    assign link.sda_host_o = 1'b0;
endmodule : vpi_i2c_host
`default_nettype wire

// ==== vpi_i2c_sva.sv ====
`default_nettype none
module vpi_i2c_sva (
    // Link
    input wire logic scl,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe,
    input wire logic sda,
    // Clock and reset
    input wire logic clk,
    input wire logic resetn
);
    // ==========
    // Bus tracking
    logic scl_q, sda_q, busy, ign, rd;
    logic [3:0] bitn;
    logic [1:0] bytes;
    logic [7:0] sh;
    wire logic dev_low = sda_dev_oe && !sda_dev_o;
    wire logic rise = scl && !scl_q;
    wire logic start = scl && scl_q && sda_q && !sda;
    wire logic stop = scl && scl_q && !sda_q && sda;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {scl_q, sda_q, busy, ign, rd} <= 5'h18;
            {bitn, bytes, sh} <= 14'h0;
        end else begin
            {scl_q, sda_q} <= {scl, sda};
            if (start) begin
                {busy, ign, rd, bitn, bytes} <= {1'b1, 8'h00};
            end else if (stop) begin
                busy <= 1'b0;
            end else if (rise && bitn == 4'h8) begin
                bitn <= 4'h0;
                bytes <= (bytes == 2'h3) ? bytes : bytes + 2'h1;
                ign <= ign || (bytes == 2'h0 && sda);
                rd <= (bytes == 2'h0) ? sh[0] : rd;
            end else if (rise) begin
                bitn <= bitn + 4'h1;
                sh <= {sh[6:0], sda};
            end
        end
    end

    // ==========
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_start; scl && $past(scl) && $fell(sda); endsequence
    sequence s_stop; scl && $past(scl) && $rose(sda); endsequence
    sequence s_ack_slot; rise && bitn == 4'h8; endsequence

    a_dev_steady: assert property (scl && $past(scl) |-> $stable(dev_low))
        else $error("device data moved while clock high");
    a_start_quiet: assert property (s_start |=> !dev_low [*8])
        else $error("device drove right after start");
    a_stop_release: assert property (s_stop |=> !dev_low [*3])
        else $error("device drove after stop");
    a_busy_only: assert property (dev_low |-> busy)
        else $error("device drove on a free bus");
    a_ack_ninth: assert property (rise && dev_low && !(rd && bytes != 2'h0) |-> bitn == 4'h8)
        else $error("device pulled low outside the ninth bit");
    a_addr_match: assert property (s_ack_slot ##0 (bytes == 2'h0)
        |-> dev_low == (sh[7:1] == vpi_pkg::MODULE_ADDR))
        else $error("address acknowledge wrong");
    a_index_range: assert property (s_ack_slot ##0 (bytes == 2'h1 && !rd && dev_low)
        |-> sh[7:4] == 4'h0)
        else $error("index out of range acknowledged");
    a_status_zero: assert property (rise && rd && bytes == 2'h1 && bitn == 4'h7 |-> !sda)
        else $error("status low bit not zero");
    a_ignore_quiet: assert property (ign |-> !dev_low)
        else $error("device drove after address mismatch");
endmodule : vpi_i2c_sva
`default_nettype wire

// ==== vpi_i2c_tb.sv ====
`default_nettype none
module vpi_i2c_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic vblank = 1'b0;
    logic supply_drop = 1'b0;
    logic [5:0] white_result = 6'h2d;
    logic req_valid = 1'b0;
    logic req_read = 1'b0;
    logic req_last = 1'b0;
    logic [7:0] req_data = 8'h00;
    logic req_ready, resp_valid, resp_nack, busy, deferred_pending, nk;
    logic [7:0] resp_data, q;
    logic [8*vpi_pkg::NUM_REGS-1:0] work_regs;
    int fails = 0;
    int comparisons = 0;

    vpi_i2c_if lnk ();
    // Short quarter keeps a bit near 128 ns
    vpi_i2c_host #(.QUARTER(8)) vpi_i2c_host_i (.link(lnk), .clk(clk), .resetn(resetn),
        .req_valid(req_valid), .req_read(req_read), .req_data(req_data), .req_last(req_last),
        .req_ready(req_ready), .resp_valid(resp_valid), .resp_data(resp_data),
        .resp_nack(resp_nack), .busy(busy));
    vpi_i2c_device vpi_i2c_device_i (.link(lnk), .clk(clk), .resetn(resetn), .vblank(vblank),
        .supply_drop(supply_drop), .white_result(white_result), .work_regs(work_regs),
        .deferred_pending(deferred_pending));
    vpi_i2c_sva vpi_i2c_sva_i (.scl(lnk.scl), .sda_dev_o(lnk.sda_dev_o),
        .sda_dev_oe(lnk.sda_dev_oe), .sda(lnk.sda), .clk(clk), .resetn(resetn));

    always #2 clk = ~clk;

    // ==========
    // Tasks
    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk8

    task automatic put(input logic [7:0] d, input logic rd, input logic last, input logic enk);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        {req_valid, req_read, req_data, req_last} = {1'b1, rd, d, last};
        do @(posedge clk); while (req_ready !== 1'b1 && ++n < 4000);
        if (n >= 4000) fails++;
        #1;
        req_valid = 1'b0;
        n = 0;
        do @(posedge clk); while (resp_valid !== 1'b1 && ++n < 4000);
        if (n >= 4000) fails++;
        q = resp_data;
        nk = resp_nack;
        if (!rd) chk8("acknowledge", {7'h0, enk}, {7'h0, nk});
    endtask : put

    task automatic idle();
        int n;
        n = 0;
        do @(posedge clk); while (busy !== 1'b0 && ++n < 4000);
        if (n >= 4000) fails++;
    endtask : idle

    task automatic final_report();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    // ==========
    // Tests
    initial begin
        repeat (2) @(posedge clk);
        #1;
        resetn = 1'b1;
        put(8'h88, 1'b0, 1'b0, 1'b0);
        put(8'h03, 1'b0, 1'b0, 1'b0);
        put(8'h2a, 1'b0, 1'b1, 1'b0);
        idle();
        chk8("index 3", 8'h2a, work_regs[8*3 +: 8]);
        chk8("index 1 reset", vpi_pkg::REG_RESET, work_regs[8*1 +: 8]);
        $display("test single done");
        put(8'h88, 1'b0, 1'b0, 1'b0);
        put(8'h0e, 1'b0, 1'b0, 1'b0);
        put(8'h11, 1'b0, 1'b0, 1'b0);
        put(8'h22, 1'b0, 1'b0, 1'b0);
        put(8'h33, 1'b0, 1'b1, 1'b0);
        idle();
        chk8("index 0 wrapped", 8'h33, work_regs[7:0]);
        chk8("index 3 kept", 8'h2a, work_regs[8*3 +: 8]);
        $display("test autoinc done");
        put(8'h90, 1'b0, 1'b1, 1'b1);
        idle();
        put(8'h88, 1'b0, 1'b0, 1'b0);
        put(8'h10, 1'b0, 1'b1, 1'b1);
        idle();
        chk8("index 0 after refusal", 8'h33, work_regs[7:0]);
        $display("test refuse done");
        put(8'h89, 1'b0, 1'b0, 1'b0);
        put(8'h00, 1'b1, 1'b1, 1'b0);
        idle();
        chk8("status", {vpi_pkg::SUPPLY_FLAG_RESET, white_result, 1'b0}, q);
        $display("test read done");
        put(8'h88, 1'b0, 1'b0, 1'b0);
        put({4'h0, vpi_pkg::IDX_CTRL1}, 1'b0, 1'b0, 1'b0);
        put(8'h01 << vpi_pkg::CTRL1_DEFER_BIT, 1'b0, 1'b1, 1'b0);
        idle();
        put(8'h88, 1'b0, 1'b0, 1'b0);
        put(8'h01, 1'b0, 1'b0, 1'b0);
        put(8'h15, 1'b0, 1'b0, 1'b0);
        put(8'h77, 1'b0, 1'b1, 1'b1);
        idle();
        chk8("held index 1", vpi_pkg::REG_RESET, work_regs[8*1 +: 8]);
        chk8("pending", 8'h01, {7'h0, deferred_pending});
        @(posedge clk);
        #1;
        vblank = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        vblank = 1'b0;
        repeat (4) @(posedge clk);
        chk8("moved index 1", 8'h15, work_regs[8*1 +: 8]);
        chk8("pending cleared", 8'h00, {7'h0, deferred_pending});
        $display("test defer done");
        final_report();
    end

    // Hang guard, well beyond the expected run
    initial begin
        #300000;
        fails++;
        final_report();
    end
endmodule : vpi_i2c_tb
`default_nettype wire
